// [core/hpp_index_window.v]
// host parallel port index/data window with byte order configuration
`timescale 1ns/1ps
`include "hpp_consts.vh"
module hpp_index_window #(
  parameter AW = 16
) (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // host pins
  input wire hp_cs_n,
  input wire hp_rd_n,
  input wire hp_wr_n,
  input wire [4:0] hp_addr,
  input wire [15:0] hp_data_i,
  output wire [15:0] hp_data_o,
  output wire hp_data_oe_n,
  // mode straps
  input wire mode_16bit,
  input wire core_direct_map_mode,
  // internal access bus
  output wire int_req,
  output wire int_wr,
  output wire [1:0] int_sel,
  output wire [AW-1:0] int_addr,
  output wire [3:0] int_be,
  output wire [31:0] int_wdata,
  input wire [31:0] int_rdata,
  input wire int_ack,
  // byte order of bypass fifo path
  output wire fifo_big_endian
);

  // ********************
  // functions
  // ********************
  function [31:0] rev;
    input [31:0] w;
    begin
      rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
  endfunction

  function [15:0] piece;
    input [31:0] w;
    input [1:0] lane;
    input m16;
    reg [31:0] s;
    begin
      s = w >> {lane, 3'b000};
      piece = m16 ? s[15:0] : {8'h00, s[7:0]};
    end
  endfunction

  function [31:0] merge;
    input [31:0] w;
    input [1:0] lane;
    input m16;
    input [15:0] d;
    reg [31:0] mask;
    reg [31:0] val;
    begin
      mask = (m16 ? 32'h0000FFFF : 32'h000000FF) << {lane, 3'b000};
      val = {16'h0000, m16 ? d : {8'h00, d[7:0]}} << {lane, 3'b000};
      merge = (w & ~mask) | (val & mask);
    end
  endfunction

  // ********************
  // pin synchronisers
  // ********************
  reg [25:0] pin_s1_q;
  reg [25:0] pin_s2_q;
  reg rd_prev_q;
  reg wr_prev_q;
  reg cs_prev_q;
  reg [4:0] a_prev_q;
  reg [15:0] d_prev_q;

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_q <= 26'h3FFFFFF;
      pin_s2_q <= 26'h3FFFFFF;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
      a_prev_q <= 5'h00;
      d_prev_q <= 16'h0000;
    end
    else
    begin
      pin_s1_q <= {hp_cs_n, hp_rd_n, hp_wr_n, mode_16bit, core_direct_map_mode, hp_addr, hp_data_i};
      pin_s2_q <= pin_s1_q;
      rd_prev_q <= pin_s2_q[24];
      wr_prev_q <= pin_s2_q[23];
      cs_prev_q <= pin_s2_q[25];
      a_prev_q <= pin_s2_q[20:16];
      d_prev_q <= pin_s2_q[15:0];
    end
  end

  wire cs_n_s = pin_s2_q[25];
  wire rd_n_s = pin_s2_q[24];
  wire wr_n_s = pin_s2_q[23];
  wire m16 = pin_s2_q[22];
  wire dmap = pin_s2_q[21];
  // read taken at strobe fall, write at strobe rise with the held address and data
  wire rd_ev = ~cs_n_s & rd_prev_q & ~rd_n_s;
  wire wr_ev = ~cs_prev_q & ~wr_prev_q & wr_n_s;
  wire [4:0] ha = wr_ev ? a_prev_q : pin_s2_q[20:16];
  wire [15:0] hd = d_prev_q;

  // ********************
  // decode
  // ********************
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  reg [1:0] st_q;
  reg [31:0] idx_q [0:2];
  reg [31:0] wbuf_q [0:3];
  reg [31:0] rbuf_q [0:3];
  reg [3:0] cfg_q;
  reg [15:0] dout_q;
  reg oe_n_q;
  reg req_q;
  reg wr_q;
  reg [1:0] sel_q;
  reg [AW-1:0] addr_q;
  reg [3:0] be_q;
  reg [31:0] wdata_q;
  reg [1:0] pend_pair_q;
  reg [1:0] pend_lane_q;
  reg pend_dir_q;
  reg pend_big_q;

  reg is_idx;
  reg is_data;
  reg is_fifo;
  reg is_cfg;
  reg [1:0] pair;

  always @*
  begin
    is_idx = 1'b0;
    is_data = 1'b0;
    is_fifo = 1'b0;
    is_cfg = 1'b0;
    pair = 2'h0;
    if (ha[4:2] == `HPP_SLOT_IDX0)
      is_idx = 1'b1;
    else if (ha[4:2] == `HPP_SLOT_DATA0)
      is_data = 1'b1;
    else if (ha[4:2] == `HPP_SLOT_IDX1)
    begin
      is_idx = 1'b1;
      pair = 2'h1;
    end
    else if (ha[4:2] == `HPP_SLOT_DATA1)
    begin
      is_data = 1'b1;
      pair = 2'h1;
    end
    else if (ha[4:2] == `HPP_SLOT_IDX2)
    begin
      is_idx = 1'b1;
      pair = 2'h2;
    end
    else if (ha[4:2] == `HPP_SLOT_DATA2)
    begin
      is_data = 1'b1;
      pair = 2'h2;
    end
    else if (ha[4:2] == `HPP_SLOT_FIFO)
    begin
      is_fifo = 1'b1;
      pair = 2'h3;
    end
    else
      is_cfg = 1'b1;
  end

  wire [1:0] lane = m16 ? {ha[1], 1'b0} : ha[1:0];
  wire last = m16 ? ha[1] : (ha[1:0] == 2'b11);
  wire first = (lane == 2'b00);
  wire big = cfg_q[pair];
  wire [1:0] ipair = (pair == 2'h3) ? 2'h0 : pair;
  wire [31:0] idx_cur = idx_q[ipair];
  wire [31:0] idx_view = big ? rev(idx_cur) : idx_cur;
  wire direct = dmap & is_data;
  // ordinary target: aligned word, low index bits dropped
  wire [AW-1:0] reg_addr = {idx_cur[AW-1:2], 2'b00};
  // direct target: pointer plus host low address bits
  wire [AW-1:0] dir_addr = m16 ? ({idx_cur[AW-1:1], 1'b0} + {{(AW-2){1'b0}}, ha[1], 1'b0})
                               : (idx_cur[AW-1:0] + {{(AW-2){1'b0}}, ha[1:0]});
  wire lbe = ~idx_cur[0];
  wire ube = ~idx_cur[`HPP_IDX_UBE_BIT];
  wire [3:0] dir_be = m16 ? (big ? {2'b00, lbe, ube} : {2'b00, ube, lbe}) : 4'b0001;
  wire [15:0] dir_wd = (m16 & big) ? {hd[7:0], hd[15:8]} : (m16 ? hd : {8'h00, hd[7:0]});
  wire [31:0] cfg_view = {4'h0, cfg_q, 4'h0, cfg_q, 4'h0, cfg_q, 4'h0, cfg_q};
  wire [3:0] cfg_wr = m16 ? (hd[3:0] | hd[11:8]) : hd[3:0];
  wire [31:0] wbuf_new = merge(wbuf_q[pair], lane, m16, hd);
  wire [31:0] idx_new = merge(idx_view, lane, m16, hd);
  wire [31:0] idx_mask = 32'h00010000 | ((32'h00000001 << AW) - 32'h00000001);

  // ********************
  // host access engine
  // ********************
  integer i;
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_IDLE;
      for (i = 0; i < 3; i = i + 1)
        idx_q[i] <= `HPP_IDX_RST;
      for (i = 0; i < 4; i = i + 1)
      begin
        wbuf_q[i] <= 32'h00000000;
        rbuf_q[i] <= 32'h00000000;
      end
      cfg_q <= `HPP_CFG_RST;
      dout_q <= 16'h0000;
      oe_n_q <= 1'b1;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      sel_q <= `HPP_SEL_REG;
      addr_q <= {AW{1'b0}};
      be_q <= 4'h0;
      wdata_q <= 32'h00000000;
      pend_pair_q <= 2'h0;
      pend_lane_q <= 2'h0;
      pend_dir_q <= 1'b0;
      pend_big_q <= 1'b0;
    end
    else
    begin
      oe_n_q <= cs_n_s | rd_n_s;
      case (st_q)
        ST_IDLE:
        begin
          if (wr_ev)
          begin
            if (is_cfg)
              cfg_q <= cfg_wr;
            else if (is_idx)
              idx_q[ipair] <= (big ? rev(idx_new) : idx_new) & idx_mask;
            else if (direct)
            begin
              req_q <= 1'b1;
              wr_q <= 1'b1;
              sel_q <= `HPP_SEL_CORE;
              addr_q <= dir_addr;
              be_q <= dir_be;
              wdata_q <= {16'h0000, dir_wd};
              st_q <= ST_BUSY;
            end
            else
            begin
              wbuf_q[pair] <= wbuf_new;
              if (last)
              begin
                req_q <= 1'b1;
                wr_q <= 1'b1;
                sel_q <= is_fifo ? `HPP_SEL_FIFO : `HPP_SEL_REG;
                addr_q <= is_fifo ? {AW{1'b0}} : reg_addr;
                be_q <= 4'hF;
                wdata_q <= big ? rev(wbuf_new) : wbuf_new;
                st_q <= ST_BUSY;
              end
            end
          end
          else if (rd_ev)
          begin
            if (is_cfg)
              dout_q <= piece(cfg_view, lane, m16);
            else if (is_idx)
              dout_q <= piece(idx_view, lane, m16);
            else if (direct | first)
            begin
              req_q <= 1'b1;
              wr_q <= 1'b0;
              sel_q <= direct ? `HPP_SEL_CORE : (is_fifo ? `HPP_SEL_FIFO : `HPP_SEL_REG);
              addr_q <= direct ? dir_addr : (is_fifo ? {AW{1'b0}} : reg_addr);
              be_q <= direct ? dir_be : 4'hF;
              pend_pair_q <= pair;
              pend_lane_q <= lane;
              pend_dir_q <= direct;
              pend_big_q <= big;
              st_q <= ST_BUSY;
            end
            else
              dout_q <= piece(rbuf_q[pair], lane, m16);
          end
        end
        ST_BUSY:
        begin
          if (int_ack)
          begin
            req_q <= 1'b0;
            st_q <= ST_IDLE;
            if (!wr_q)
            begin
              if (pend_dir_q)
                dout_q <= (m16 & pend_big_q) ? {int_rdata[7:0], int_rdata[15:8]}
                        : (m16 ? int_rdata[15:0] : {8'h00, int_rdata[7:0]});
              else
              begin
                rbuf_q[pend_pair_q] <= pend_big_q ? rev(int_rdata) : int_rdata;
                dout_q <= piece(pend_big_q ? rev(int_rdata) : int_rdata, pend_lane_q, m16);
              end
            end
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // ********************
  // outputs
  // ********************
  assign hp_data_o = dout_q;
  assign hp_data_oe_n = oe_n_q;
  assign int_req = req_q;
  assign int_wr = wr_q;
  assign int_sel = sel_q;
  assign int_addr = addr_q;
  assign int_be = be_q;
  assign int_wdata = wdata_q;
  assign fifo_big_endian = cfg_q[`HPP_CFG_FIFO_BIT];

endmodule

// [core/hpp_consts.vh]
// constants of the host parallel port index/data window
//
// Notes on behaviour
// - 16-bit direct mode: index upper-byte enable bit is active low, reads and writes.
// - Upper-byte enable is ignored for ordinary registers; they are full words.
// - Every index register holds a byte address used for its data register.
// - Ordinary registers: index bits 1:0 ignored, aligned 32-bit access.
// - 16-bit direct mode: index bit 0 is an active-low lower-byte enable.
// - Each data register is a four-byte window onto the indexed register.
// - Ordinary registers: host pieces assemble into one word write, reads split.
// - Host address 1:0 picks a byte in 8-bit mode, bit 1 a word in 16-bit.
// - Direct mode allows unaligned access; index bits 1:0 join the pointer in 8-bit mode, only bit 1 in 16-bit.
// - Direct mode internal accesses are at host bus width.
// - Direct mode adds host address 1:0 to the index address in 8-bit mode, only host address bit 1 in 16-bit.
// - Configuration holds one endianness bit per pair plus one for the FIFO path.
// - Configuration takes byte or word writes at once, no assembly.
// - Each configuration byte is replicated into all four byte positions.
// - Bits 27 and 19 mirror FIFO endianness bit 3, read/write, reset zero.
// - Bits 26..24 mirror pair endianness bits 2..0, reset zero.
// - Writing a one into any copy of a mirrored bit sets all copies.
// - FIFO endianness bit: 0 little endian, 1 big endian, for bypass path.
`ifndef HPP_CONSTS_VH
`define HPP_CONSTS_VH
// slot number = host byte address / 4
`define HPP_SLOT_IDX0 3'h0
`define HPP_SLOT_DATA0 3'h1
`define HPP_SLOT_IDX1 3'h2
`define HPP_SLOT_DATA1 3'h3
`define HPP_SLOT_IDX2 3'h4
`define HPP_SLOT_DATA2 3'h5
`define HPP_SLOT_FIFO 3'h6
`define HPP_SLOT_CFG 3'h7
// index register fields
`define HPP_IDX_UBE_BIT 16
`define HPP_IDX_RST 32'h00000000
// configuration
`define HPP_CFG_FIFO_BIT 3
`define HPP_CFG_RST 4'h0
// internal target select
`define HPP_SEL_REG 2'h0
`define HPP_SEL_CORE 2'h1
`define HPP_SEL_FIFO 2'h2
`endif

// [dv/hidw_chk.sv]
// assertions on the index window ports
`timescale 1ns/1ps
module hidw_chk #(
  parameter AW = 16
) (
  // clock, reset, host
  input wire mclk,
  input wire nrst,
  input wire hp_rd_n,
  input wire hp_data_oe_n,
  input wire mode_16bit,
  input wire core_direct_map_mode,
  // internal bus
  input wire int_req,
  input wire int_ack,
  input wire int_wr,
  input wire [1:0] int_sel,
  input wire [AW-1:0] int_addr,
  input wire [3:0] int_be,
  input wire [31:0] int_wdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_held;
    int_req && $stable(int_addr) && $stable(int_be) && $stable(int_wdata) && $stable(int_wr);
  endsequence
  AST_HOLD: assert property (int_req && !int_ack |=> s_held) else $error("request moved");
  AST_DROP: assert property (int_req && int_ack |=> !int_req) else $error("request kept");
  AST_ORD_BE: assert property (int_req && int_sel == 2'h0 |-> int_be == 4'hF) else $error("part word");
  AST_ORD_AL: assert property (int_req && int_sel == 2'h0 |-> int_addr[1:0] == 2'h0) else $error("unaligned");
  AST_D8_BE: assert property (int_req && int_sel == 2'h1 && !mode_16bit |-> int_be == 4'h1) else $error("be8");
  AST_D16_BE: assert property (int_req && int_sel == 2'h1 && mode_16bit |-> int_be[3:2] == 2'h0) else $error("be16");
  AST_SEL_MODE: assert property (int_req && int_sel == 2'h1 |-> core_direct_map_mode) else $error("sel");
  AST_OE: assert property ($rose(hp_rd_n) |-> ##[1:4] hp_data_oe_n) else $error("oe held");
endmodule
bind hpp_index_window hidw_chk #(.AW(AW)) u_chk (.mclk(mclk), .nrst(nrst), .hp_rd_n(hp_rd_n),
  .hp_data_oe_n(hp_data_oe_n), .mode_16bit(mode_16bit), .core_direct_map_mode(core_direct_map_mode),
  .int_req(int_req), .int_ack(int_ack), .int_wr(int_wr), .int_sel(int_sel), .int_addr(int_addr),
  .int_be(int_be), .int_wdata(int_wdata));

// [dv/hidw_int_target.sv]
// internal bus target answering the window
`timescale 1ns/1ps
module hidw_int_target (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // internal bus
  input wire int_req,
  input wire int_wr,
  input wire [15:0] int_addr,
  input wire [3:0] int_be,
  input wire [31:0] int_wdata,
  output logic [31:0] int_rdata,
  output logic int_ack,
  // answer delay
  input wire [3:0] dly
);
  logic [3:0] cnt_q;
  logic [31:0] mem_q;
  logic [15:0] last_addr_q;
  logic [3:0] last_be_q;
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 4'h0;
      int_ack <= 1'b0;
      int_rdata <= 32'h0;
      mem_q <= 32'h0;
    end
    else
    begin
      int_ack <= 1'b0;
      int_rdata <= ~int_rdata;
      if (int_req && !int_ack)
        cnt_q <= cnt_q + 4'h1;
      if (int_req && !int_ack && cnt_q >= dly)
      begin
        cnt_q <= 4'h0;
        int_ack <= 1'b1;
        last_addr_q <= int_addr;
        last_be_q <= int_be;
        if (int_wr)
          mem_q <= int_wdata;
        else
          int_rdata <= mem_q;
      end
    end
  end
endmodule

// [dv/host_index_data_window_tb_top.sv]
// testbench of the index/data window
`timescale 1ns/1ps
module host_index_data_window_tb_top;
  logic mclk = 0, nrst = 0, cs_n = 1, rd_n = 1, wr_n = 1, m16 = 1, dm = 0;
  logic [4:0] ad = 5'h00;
  logic [15:0] di = 16'h0000;
  logic [3:0] dly = 4'h0;
  wire [31:0] rdat, wd;
  wire [15:0] dout, ia;
  wire [3:0] be;
  wire [1:0] sel;
  wire ack, req, wr, oe_n, fbe;
  int num_errors = 0, checks = 0, cyc = 0;
  hpp_index_window dut (.mclk(mclk), .nrst(nrst), .hp_cs_n(cs_n), .hp_rd_n(rd_n), .hp_wr_n(wr_n), .hp_addr(ad),
    .hp_data_i(di), .hp_data_o(dout), .hp_data_oe_n(oe_n), .mode_16bit(m16), .core_direct_map_mode(dm),
    .int_req(req), .int_wr(wr), .int_sel(sel), .int_addr(ia), .int_be(be), .int_wdata(wd), .int_rdata(rdat),
    .int_ack(ack), .fifo_big_endian(fbe));
  hidw_int_target tgt (.mclk(mclk), .nrst(nrst), .int_req(req), .int_wr(wr), .int_addr(ia), .int_be(be),
    .int_wdata(wd), .int_rdata(rdat), .int_ack(ack), .dly(dly));
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      close_out();
    end
  end
  task close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task hw(input logic [4:0] a, input logic [15:0] d);
    ad = a;
    di = d;
    cs_n = 0;
    wr_n = 0;
    tick(4);
    wr_n = 1;
    tick(1);
    cs_n = 1;
    tick(14);
  endtask
  task hr(input logic [4:0] a, output logic [15:0] d);
    ad = a;
    cs_n = 0;
    rd_n = 0;
    tick(14);
    d = dout;
    chk(oe_n, 32'h0);
    rd_n = 1;
    cs_n = 1;
    tick(3);
  endtask
  task rd32(input logic [4:0] a, output logic [31:0] w);
    logic [15:0] l, h;
    hr(a, l);
    hr(a + 5'h02, h);
    w = {h, l};
  endtask
  task t_ord;
    logic [31:0] w;
    dly = 4'h3;
    hw(5'h00, 16'h5677);
    hw(5'h02, 16'h0001);
    hw(5'h04, 16'hBEEF);
    hw(5'h06, 16'hDEAD);
    chk(tgt.last_addr_q, 32'h5674);
    chk(tgt.last_be_q, 32'hF);
    chk(tgt.mem_q, 32'hDEADBEEF);
    chk(sel, 32'h0);
    rd32(5'h04, w);
    chk(w, 32'hDEADBEEF);
    chk(wr, 32'h0);
  endtask
  task t_dir;
    logic [15:0] d;
    dm = 1;
    dly = 4'h0;
    hw(5'h08, 16'h0100);
    hw(5'h0A, 16'h0001);
    hw(5'h0E, 16'h00A5);
    chk(tgt.last_addr_q, 32'h0102);
    chk(tgt.last_be_q, 32'h1);
    chk(sel, 32'h1);
    hw(5'h08, 16'h0101);
    hw(5'h0A, 16'h0000);
    hw(5'h0C, 16'h1234);
    chk(tgt.last_be_q, 32'h2);
    chk(tgt.mem_q[15:0], 32'h1234);
    m16 = 0;
    dly = 4'h5;
    hw(5'h08, 16'h0021);
    hw(5'h0F, 16'h005A);
    chk(tgt.last_addr_q, 32'h0124);
    hr(5'h0D, d);
    chk(tgt.last_addr_q, 32'h0122);
    chk(d, 32'h005A);
    m16 = 1;
    dm = 0;
  endtask
  task t_cfg;
    logic [31:0] w;
    rd32(5'h1C, w);
    chk(w, 32'h0);
    hw(5'h1C, 16'h08F0);
    rd32(5'h1C, w);
    chk(w, 32'h08080808);
    chk(fbe, 32'h1);
    hw(5'h1E, 16'h0201);
    rd32(5'h1C, w);
    chk(w, 32'h03030303);
    chk(fbe, 32'h0);
  endtask
  task t_end;
    logic [31:0] w;
    rd32(5'h00, w);
    chk(w, 32'h77560100);
    hw(5'h04, 16'h1122);
    hw(5'h06, 16'h3344);
    chk(tgt.mem_q, 32'h22114433);
    rd32(5'h04, w);
    chk(w, 32'h33441122);
    hw(5'h18, 16'h5555);
    hw(5'h1A, 16'h6666);
    chk(tgt.mem_q, 32'h66665555);
    chk(sel, 32'h2);
    chk(wr, 32'h1);
    chk(tgt.last_be_q, 32'hF);
  endtask
  initial
  begin
    tick(10);
    nrst = 1;
    tick(3);
    chk(fbe, 32'h0);
    t_ord();
    t_dir();
    t_cfg();
    t_end();
    close_out();
  end
endmodule
